// ===== dts_chk.sv
// Assertion checker for the debug trace status block.
// Bound to dts_status by the bench top file; sees only its ports.
`timescale 1ns/1ps
module dts_chk
	import dts_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        nrst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [9:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        internal_trigger,
	input wire logic        session_armed,
	input wire logic        irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	wire tk = wb_cyc_i & wb_stb_i & !wb_ack_o;
	wire cw = tk & wb_we_i & wb_sel_i[0] & (wb_adr_i[9:2] == IDX_CONTROL);
	AST_ACK: assert property (tk |=> wb_ack_o) else $error("ack missing");
	AST_ACK1: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	AST_IDLE: assert property (!wb_cyc_i |=> !wb_ack_o) else $error("stray ack");
	AST_DAT: assert property (!wb_ack_o |-> wb_dat_o == DATA_ZERO) else $error("data leak");
	AST_ARM: assert property (cw & wb_dat_i[BIT_ARM] |=> session_armed) else $error("no arm");
	AST_OFF: assert property (cw & !wb_dat_i[BIT_ARM] |=> !session_armed) else $error("no off");
	AST_TRIG: assert property (internal_trigger & !cw |=> !session_armed) else $error("trig");
	AST_HOLD: assert property (!cw & !internal_trigger |=> $stable(session_armed))
		else $error("arm moved");
	COV_ARM: cover property (cw ##1 session_armed);
	COV_END: cover property (session_armed ##1 !session_armed);
	COV_IRQ: cover property ($rose(irq));
endmodule

// ===== dts_pkg.sv
// Constants for the debug trace status block: register map, fields, states.
// Assumes a classic Wishbone slave with 32-bit data and byte addressing.
// Behaviour
// - Set trace full after 64 stored lines.
// - Trace full makes all 64 lines valid.
// - Writing arm one clears trace full.
// - Of the two resets, only power-on reset clears trace full.
// - Bit 6 flags external tag hit since arming.
// - Writing arm one clears tag hit flag.
// - Sequencer field follows each new state.
// - Software disarm keeps last sequencer state.
// - Internal trigger while armed returns sequencer to disarmed.
// - Arming enters state one, field 001.
// - Codes: 000,001,010,011,100; rest reserved.
package dts_pkg;
	localparam int ADDR_W = 8;
	// The printed offset 0x21 is not a multiple of four, so it is an index.
	localparam logic [ADDR_W-1:0] IDX_STATUS  = 8'h21;
	localparam logic [ADDR_W-1:0] IDX_CONTROL = 8'h20;
	localparam logic [ADDR_W-1:0] IDX_IRQ_ST  = 8'h22;
	localparam logic [ADDR_W-1:0] IDX_IRQ_MSK = 8'h23;
	localparam logic [ADDR_W-1:0] IDX_COUNT   = 8'h24;
	localparam int BIT_FULL  = 7;
	localparam int BIT_EXT   = 6;
	localparam int BIT_ARM   = 7;
	localparam int SSF_W     = 3;
	localparam int EV_W      = 3;
	localparam int EV_FULL   = 0;
	localparam int EV_EXT    = 1;
	localparam int EV_TRIG   = 2;
	localparam int TRACE_LINES = 64;
	localparam int CNT_W     = 7;
	localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
	typedef enum logic [SSF_W-1:0] {
		ST_DISARMED = 3'h0,
		ST_ONE      = 3'h1,
		ST_TWO      = 3'h2,
		ST_THREE    = 3'h3,
		ST_FINAL    = 3'h4
	} dts_state_t;
endpackage

// ===== dts_status.sv
// Debug trace status block: arm control, trace-full and tag-hit flags,
// state sequencer and a small interrupt unit on a Wishbone slave port.
// Assumes trace stores, tag hits and sequencer steps are one-cycle pulses
// synchronous to clk_sys; por_n low marks a power-on reset only.
`timescale 1ns/1ps
module dts_status
	import dts_pkg::*;
(
	input  wire logic                    clk_sys,
	input  wire logic                    nrst,
	input  wire logic                    por_n,
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [dts_pkg::ADDR_W+1:0] wb_adr_i,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic [31:0]             wb_dat_i,
	output logic      [31:0]             wb_dat_o,
	output logic                         wb_ack_o,
	input  wire logic                    trace_store,
	input  wire logic                    tag_input_high,
	input  wire logic                    tag_input_low,
	input  wire logic                    seq_advance,
	input  wire logic                    internal_trigger,
	output logic                         session_armed,
	output logic                         irq
);
	import dts_pkg::*;

	logic                   trace_full_flag;
	logic                   external_tag_hit_flag;
	dts_state_t             seq_state;
	logic [CNT_W-1:0]       trace_line_count;
	logic [EV_W-1:0]        irq_status;
	logic [EV_W-1:0]        irq_mask;

	function automatic dts_state_t step_state(input dts_state_t s);
		case (s)
			ST_ONE:   step_state = ST_TWO;
			ST_TWO:   step_state = ST_THREE;
			ST_THREE: step_state = ST_FINAL;
			default:  step_state = s;
		endcase
	endfunction

	wire                req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire [ADDR_W-1:0]   idx       = wb_adr_i[ADDR_W+1:2];
	wire                wr        = req && wb_we_i && wb_sel_i[0];
	wire                rd        = req && !wb_we_i;
	wire                wr_ctrl   = wr && idx == IDX_CONTROL;
	wire                arm_write = wr_ctrl && wb_dat_i[BIT_ARM];
	wire                disarm_sw = wr_ctrl && !wb_dat_i[BIT_ARM];
	wire                wr_mask   = wr && idx == IDX_IRQ_MSK;
	wire                rd_irq_st = rd && idx == IDX_IRQ_ST;
	wire                trig_end  = session_armed && internal_trigger && !arm_write;
	wire                tag_hit   = tag_input_high || tag_input_low;
	wire                store_ok  = session_armed && trace_store;
	// Count wraps mod 128 so a full buffer keeps the oldest 64 valid.
	wire [CNT_W-1:0]    cnt_inc   = trace_line_count + 7'h01;
	wire                full_hit  = store_ok && (32'(cnt_inc) >= TRACE_LINES);
	wire                ext_hit   = session_armed && tag_hit;
	wire [EV_W-1:0]     events    = {trig_end, ext_hit, full_hit};
	wire [EV_W-1:0]     next_irq_status = (rd_irq_st ? {EV_W{1'b0}} : irq_status) | events;
	wire [EV_W-1:0]     next_irq_mask   = wr_mask ? wb_dat_i[EV_W-1:0] : irq_mask;
	wire [SSF_W-1:0]    ssf       = seq_state;
	wire [7:0]          status_rd = {trace_full_flag, external_tag_hit_flag, 3'b000, ssf};
	wire [7:0]          ctrl_rd   = {session_armed, 7'h00};
	wire                mapped    = idx == IDX_STATUS || idx == IDX_CONTROL
		|| idx == IDX_IRQ_ST || idx == IDX_IRQ_MSK || idx == IDX_COUNT;
	// Status at IDX_STATUS has no write path at all.
	wire [31:0]         next_dat  =
		!mapped             ? DATA_ZERO :
		idx == IDX_STATUS   ? {24'h00_0000, status_rd} :
		idx == IDX_CONTROL  ? {24'h00_0000, ctrl_rd} :
		idx == IDX_IRQ_ST   ? {29'h0, irq_status} :
		idx == IDX_IRQ_MSK  ? {29'h0, irq_mask} :
		{25'h0, trace_line_count};

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= DATA_ZERO;
		end
		else
		begin
			wb_ack_o <= req;
			wb_dat_o <= rd ? next_dat : DATA_ZERO;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			session_armed <= 1'b0;
		else if (arm_write)
			session_armed <= 1'b1;
		else if (disarm_sw || trig_end)
			session_armed <= 1'b0;
	end

	// Of the two resets, power-on reset alone clears trace full; system reset leaves it.
	always_ff @(posedge clk_sys or negedge por_n)
	begin
		if (!por_n)
			trace_full_flag <= 1'b0;
		else if (arm_write)
			trace_full_flag <= 1'b0;
		else if (full_hit)
			trace_full_flag <= 1'b1;
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			external_tag_hit_flag <= 1'b0;
			trace_line_count      <= CNT_ZERO;
		end
		else if (arm_write)
		begin
			external_tag_hit_flag <= 1'b0;
			trace_line_count      <= CNT_ZERO;
		end
		else
		begin
			if (ext_hit)
				external_tag_hit_flag <= 1'b1;
			if (store_ok)
				trace_line_count <= cnt_inc;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			seq_state <= ST_DISARMED;
		else if (arm_write)
			seq_state <= ST_ONE;
		else if (trig_end)
			seq_state <= ST_DISARMED;
		else if (session_armed && !disarm_sw && seq_advance)
			seq_state <= step_state(seq_state);
		// A software disarm takes no branch, so the last state stays.
	end

	// Set wins over the clear-on-read in the same cycle.
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			irq_status <= '0;
			irq_mask   <= '0;
			irq        <= 1'b0;
		end
		else
		begin
			irq_status <= next_irq_status;
			irq_mask   <= next_irq_mask;
			// Both next values feed irq, so a mask write shows with no stale cycle.
			irq        <= |(next_irq_status & next_irq_mask);
		end
	end
endmodule

// ===== dts_status_bench.sv
// Self-checking bench for dts_status over classic Wishbone.
// Expected bus data is queued by the driver and checked on each ack.
`timescale 1ns/1ps
module dts_status_bench;
	import dts_pkg::*;
	logic clk_sys, nrst, por_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, session_armed;
	logic [9:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [31:0] notes[$];
	logic [4:0]  evs;
	logic [7:0]  s;
	wire trace_store, tag_input_high, seq_advance, internal_trigger, tag_input_low;
	int miscompares, checked, ticks, seed, r;
	assign {tag_input_low, internal_trigger, seq_advance, tag_input_high, trace_store} = evs;
	dts_status i_dut (
		.clk_sys          (clk_sys),
		.nrst             (nrst),
		.por_n            (por_n),
		.wb_cyc_i         (wb_cyc_i),
		.wb_stb_i         (wb_stb_i),
		.wb_we_i          (wb_we_i),
		.wb_adr_i         (wb_adr_i),
		.wb_sel_i         (wb_sel_i),
		.wb_dat_i         (wb_dat_i),
		.wb_dat_o         (wb_dat_o),
		.wb_ack_o         (wb_ack_o),
		.trace_store      (trace_store),
		.tag_input_high   (tag_input_high),
		.tag_input_low    (tag_input_low),
		.seq_advance      (seq_advance),
		.internal_trigger (internal_trigger),
		.session_armed    (session_armed),
		.irq              (irq)
	);
	initial
	begin
		clk_sys = 0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		ticks++;
		if (ticks > 5000)
		begin
			miscompares++;
			wrap_up();
		end
		else if (wb_ack_o)
			chk(wb_dat_o, notes.pop_front());
	end
	// The master waits on ack with no assumed latency; the tick ceiling ends a hang.
	task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d, e);
		notes.push_back({24'h0000_00, e});
		@(posedge clk_sys);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
		wb_adr_i <= {i, 2'b00};
		wb_dat_i <= {24'h0000_00, d};
		do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	task automatic ev(input logic [4:0] m, input int n);
		@(posedge clk_sys);
		evs <= m;
		repeat (n) @(posedge clk_sys);
		evs <= 5'h00;
	endtask
	task automatic rst(input logic p);
		@(posedge clk_sys);
		{nrst, por_n} <= {1'b0, p};
		repeat (2) @(posedge clk_sys);
		{nrst, por_n} <= 2'b11;
	endtask
	initial
	begin
		seed = 23771;
		{nrst, por_n, wb_cyc_i, wb_stb_i, wb_we_i, evs, wb_adr_i, wb_dat_i} = 0;
		wb_sel_i = 4'hf;
		repeat (16) @(posedge clk_sys);
		{nrst, por_n} <= 2'b11;
		bus(1, IDX_STATUS, 8'hff, 0);
		bus(0, IDX_STATUS, 0, 0);
		bus(0, 8'h30, 0, 0);
		bus(1, IDX_CONTROL, 8'h80, 0);
		bus(0, IDX_STATUS, 0, 8'h01);
		bus(0, IDX_CONTROL, 0, 8'h80);
		r = $unsigned($random(seed)) % 4;
		s = (r > 1) ? 8'h04 : 8'(r + 2);
		ev(5'h04, r + 1);
		bus(0, IDX_STATUS, 0, s);
		ev(5'h01, 63);
		bus(0, IDX_STATUS, 0, s);
		ev(5'h01, 1);
		bus(0, IDX_STATUS, 0, 8'h80 | s);
		bus(0, IDX_COUNT, 0, 8'h40);
		chk({31'h0, irq}, 0);
		ev(5'h10, 1);
		bus(1, IDX_CONTROL, 0, 0);
		bus(0, IDX_STATUS, 0, 8'hc0 | s);
		$display("test flags done");
		rst(1);
		bus(0, IDX_STATUS, 0, 8'h80);
		bus(1, IDX_IRQ_MSK, 8'h04, 0);
		bus(0, IDX_IRQ_MSK, 0, 8'h04);
		bus(1, IDX_CONTROL, 8'h80, 0);
		bus(0, IDX_STATUS, 0, 8'h01);
		ev(5'h02, 1);
		ev(5'h08, 1);
		bus(0, IDX_STATUS, 0, 8'h40);
		chk({31'h0, irq}, 1);
		bus(0, IDX_IRQ_ST, 0, 8'h06);
		@(negedge clk_sys);
		chk({31'h0, irq}, 0);
		$display("test irq done");
		rst(0);
		bus(0, IDX_STATUS, 0, 0);
		$display("test por done");
		wrap_up();
	end
endmodule
bind dts_status dts_chk u_chk (
	.clk_sys          (clk_sys),
	.nrst             (nrst),
	.wb_cyc_i         (wb_cyc_i),
	.wb_stb_i         (wb_stb_i),
	.wb_we_i          (wb_we_i),
	.wb_adr_i         (wb_adr_i),
	.wb_sel_i         (wb_sel_i),
	.wb_dat_i         (wb_dat_i),
	.wb_dat_o         (wb_dat_o),
	.wb_ack_o         (wb_ack_o),
	.internal_trigger (internal_trigger),
	.session_armed    (session_armed),
	.irq              (irq)
);
